// ---- inc/otp_cfg.svh ----
`ifndef OTP_CFG_SVH
`define OTP_CFG_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define OTP_OFS_MEMCTL  8'h00
`define OTP_OFS_PMODE1  8'h04
`define OTP_OFS_STATUS  8'h08

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define OTP_BIT_STOPEN  0
`define OTP_BIT_PDREQ   1
`define OTP_BIT_EXTAREA 3
`define OTP_BIT_IDOK    0
`define OTP_BIT_RDBLK   1
`define OTP_BIT_SBOOT   2
`define OTP_BIT_UART    3
`define OTP_BIT_PWRDN   4

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define OTP_RST_STOPEN  1'b0
`define OTP_RST_PDREQ   1'b0
`define OTP_RST_EXTAREA 1'b0

// ---------------------------------------------------------------
// stored-content codes and locations
// ---------------------------------------------------------------
`define OTP_PROT_ADDR   24'h0FFFFF
`define OTP_PROT_ON     8'h3F
`define OTP_PROT_OFF0   8'h00
`define OTP_PROT_OFF1   8'hFF
`define OTP_ID_FIRST    24'h0FFFDF
`define OTP_ID_LAST     24'h0FFFFB
`define OTP_ID_LEN      7
`define OTP_VEC_ERASED  32'hFFFFFFFF

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define OTP_CLK_HZ      50000000
`define OTP_UART_BAUD   9600
`define OTP_UART_DIV    (`OTP_CLK_HZ / `OTP_UART_BAUD)
`define OTP_BUSY_CYC    8

`endif

// ---- inc/otp_pkg.sv ----
package otp_pkg;

  // ---------------------------------------------------------------
  // receiver states
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } otp_rx_t;

endpackage

// ---- src/otp_ctrl.sv ----
// Design decisions made here: the address map and the APB register port.
`include "otp_cfg.svh"

// Overview of operation
// - program memory written only through serial boot commands; no erase exists
// - external-area bit reads 1 while stop-control enable is 1
// - clearing stop-control enable restores the previous external-area value
// - external-area writes during enable are held and applied after clear
// - without the external-area bit, external area never follows the enable
// - powerdown request acts only with enable set; still writable otherwise
// - protect byte 3Fh blocks parallel-mode reads of the memory
// - 00h or FFh leaves protection off; programmer stores nothing else
// - serial boot commands ignored until received ID matches stored ID
// - erased all-ones reset vector skips the ID comparison
// - stored ID is seven bytes from 0FFFDFh to 0FFFFBh, first byte first
// - serial output pull-up enabled while reset pin is low in serial boot
// - mode 1: external serial clock, busy output; mode 2: busy shows activity
// - mode 1 clock-synchronous transfer, mode 2 UART framing
// - protection only in parallel mode, ID check only in serial boot
module otp_ctrl #(
  parameter int          UART_DIV     = `OTP_UART_DIV,
  parameter bit          HAS_EXT_AREA = 1'b1
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // stored memory content
  input  wire logic [7:0]  prot_byte,
  input  wire logic [55:0] stored_id,
  input  wire logic [31:0] reset_vector,
  // device pins
  input  wire logic        rst_pin_n,
  input  wire logic        boot_mode_select_in,
  input  wire logic        par_mode_in,
  input  wire logic        uart_mode_in,
  input  wire logic        boot_sclk_in,
  input  wire logic        boot_serial_in,
  output logic             boot_serial_out,
  output logic             boot_serial_out_pullup,
  output logic             boot_busy,
  // memory side
  output logic             par_read_block,
  output logic             mem_powerdown,
  output logic             ext_area_expand,
  output logic             prog_cmd_valid,
  output logic [7:0]       prog_cmd_byte
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (UART_DIV < 4 || UART_DIV > 65535)
  begin : g_chk
    $error("UART_DIV out of range");
  end

  localparam logic [15:0] DIV   = 16'(UART_DIV);
  localparam logic [15:0] HALF  = 16'(UART_DIV / 2);
  localparam logic [3:0]  BUSYC = 4'(`OTP_BUSY_CYC);
  localparam logic [2:0]  IDL   = 3'(`OTP_ID_LEN - 1);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [5:0] pins;
  logic       sclk_d_reg;

  assign pins = {par_mode_in, uart_mode_in, boot_mode_select_in,
                 rst_pin_n, boot_sclk_in, boot_serial_in};

  // first stage feeds only the second stage; reset to the inactive pin levels
  // (parallel and uart mode low) so no false protect or mode shows after reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sync1_reg  <= 6'h0F;
      sync2_reg  <= 6'h0F;
      sclk_d_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      sync1_reg  <= pins;
      sync2_reg  <= sync1_reg;
      sclk_d_reg <= sync2_reg[1];
    end
  end

  logic rxd_s;
  logic sclk_s;
  logic rpin_n_s;
  logic sboot_s;
  logic uart_s;
  logic par_s;

  assign rxd_s    = sync2_reg[0];
  assign sclk_s   = sync2_reg[1];
  assign rpin_n_s = sync2_reg[2];
  assign sboot_s  = ~sync2_reg[3];     // select pin low means serial boot
  assign uart_s   = sync2_reg[4];
  assign par_s    = sync2_reg[5];

  // ---------------------------------------------------------------
  // register file and apb
  // ---------------------------------------------------------------
  logic        stopen_reg, stopen_next;
  logic        pdreq_reg, pdreq_next;
  logic        ext_sw_reg, ext_sw_next;
  logic        pready_next;
  logic [31:0] prdata_next;
  logic        pslverr_next;
  logic        pwrdn_next, ext_next, blk_next;
  logic        id_ok_reg;
  logic        acc, wr_ok;
  logic        ext_eff;

  assign acc   = psel & penable & ~pready;
  assign wr_ok = psel & penable & pready & pwrite & ~pslverr;

  // effective bit: forced while enable set, software value otherwise
  assign ext_eff = HAS_EXT_AREA & (stopen_reg | ext_sw_reg);

  always_comb
  begin
    stopen_next  = stopen_reg;
    pdreq_next   = pdreq_reg;
    ext_sw_next  = ext_sw_reg;
    pready_next  = acc;                // one wait state on every access
    prdata_next  = prdata;
    pslverr_next = 1'b0;
    if (acc)
    begin
      prdata_next = 32'h0;
      case (paddr)
        `OTP_OFS_MEMCTL:
        begin
          prdata_next[`OTP_BIT_STOPEN] = stopen_reg;
          prdata_next[`OTP_BIT_PDREQ]  = pdreq_reg;
        end
        `OTP_OFS_PMODE1: prdata_next[`OTP_BIT_EXTAREA] = ext_eff;
        `OTP_OFS_STATUS:
        begin
          prdata_next[`OTP_BIT_IDOK]  = id_ok_reg;
          prdata_next[`OTP_BIT_RDBLK] = par_read_block;
          prdata_next[`OTP_BIT_SBOOT] = sboot_s;
          prdata_next[`OTP_BIT_UART]  = uart_s;
          prdata_next[`OTP_BIT_PWRDN] = mem_powerdown;
        end
        default: pslverr_next = 1'b1;  // unmapped offset
      endcase
    end
    if (wr_ok)
    begin
      case (paddr)
        `OTP_OFS_MEMCTL:
        begin
          stopen_next = pwdata[`OTP_BIT_STOPEN];
          pdreq_next  = pwdata[`OTP_BIT_PDREQ];
        end
        // held in the shadow while enable set, seen after it clears
        `OTP_OFS_PMODE1: ext_sw_next = pwdata[`OTP_BIT_EXTAREA];
        default: ;
      endcase
    end
    pwrdn_next = stopen_next & pdreq_next;
    ext_next   = HAS_EXT_AREA & (stopen_next | ext_sw_next);
    // 3Fh blocks; 00h, FFh and anything else leave reads open
    blk_next   = par_s & ~sboot_s & (prot_byte == `OTP_PROT_ON);
  end

  // register stage of the bus group
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      stopen_reg      <= `OTP_RST_STOPEN;
      pdreq_reg       <= `OTP_RST_PDREQ;
      ext_sw_reg      <= `OTP_RST_EXTAREA;
      pready          <= 1'b0;
      prdata          <= 32'h0;
      pslverr         <= 1'b0;
      mem_powerdown   <= 1'b0;
      ext_area_expand <= 1'b0;
      par_read_block  <= 1'b0;
    end
    else if (clk_en)
    begin
      stopen_reg      <= stopen_next;
      pdreq_reg       <= pdreq_next;
      ext_sw_reg      <= ext_sw_next;
      pready          <= pready_next;
      prdata          <= prdata_next;
      pslverr         <= pslverr_next;
      mem_powerdown   <= pwrdn_next;
      ext_area_expand <= ext_next;
      par_read_block  <= blk_next;
    end
  end

  // ---------------------------------------------------------------
  // boot link receiver and id gate
  // ---------------------------------------------------------------
  otp_pkg::otp_rx_t rx_reg, rx_next;
  logic [15:0] baud_reg, baud_next;
  logic [2:0]  bit_reg, bit_next;
  logic [7:0]  shf_reg, shf_next;
  logic [2:0]  idx_reg, idx_next;
  logic        mis_reg, mis_next;
  logic        id_ok_next;
  logic [3:0]  bcnt_reg, bcnt_next;
  logic        cmd_v_next;
  logic [7:0]  cmd_b_next;
  logic        busy_next;
  logic        pull_next;
  logic        byte_done;
  logic [7:0]  byte_val;
  logic        link_on;
  logic        skip_id;
  logic        sclk_rise;

  assign link_on   = sboot_s & rpin_n_s;
  assign skip_id   = (reset_vector == `OTP_VEC_ERASED);
  assign sclk_rise = sclk_s & ~sclk_d_reg;

  always_comb
  begin
    rx_next    = rx_reg;
    baud_next  = baud_reg;
    bit_next   = bit_reg;
    shf_next   = shf_reg;
    idx_next   = idx_reg;
    mis_next   = mis_reg;
    id_ok_next = id_ok_reg;
    bcnt_next  = (bcnt_reg != 4'h0) ? bcnt_reg - 4'h1 : 4'h0;
    cmd_v_next = 1'b0;
    cmd_b_next = prog_cmd_byte;
    byte_done  = 1'b0;
    byte_val   = 8'h0;
    if (uart_s)
    begin
      // uart 8N1, lsb first, sampled mid-bit
      case (rx_reg)
        otp_pkg::RX_IDLE:
          if (!rxd_s)
          begin
            rx_next   = otp_pkg::RX_START;
            baud_next = HALF;
          end
        otp_pkg::RX_START:
          if (baud_reg != 16'h0)
            baud_next = baud_reg - 16'h1;
          else if (rxd_s)
            rx_next = otp_pkg::RX_IDLE;                  // glitch, not a start bit
          else
          begin
            rx_next   = otp_pkg::RX_DATA;
            baud_next = DIV - 16'h1;
            bit_next  = 3'h0;
          end
        otp_pkg::RX_DATA:
          if (baud_reg != 16'h0)
            baud_next = baud_reg - 16'h1;
          else
          begin
            shf_next  = {rxd_s, shf_reg[7:1]};
            baud_next = DIV - 16'h1;
            bit_next  = bit_reg + 3'h1;
            if (bit_reg == 3'h7)
              rx_next = otp_pkg::RX_STOP;
          end
        otp_pkg::RX_STOP:
          if (baud_reg != 16'h0)
            baud_next = baud_reg - 16'h1;
          else
          begin
            rx_next   = otp_pkg::RX_IDLE;
            byte_done = rxd_s;                           // framing error drops byte
            byte_val  = shf_reg;
          end
        default: rx_next = otp_pkg::RX_IDLE;
      endcase
    end
    else if (sclk_rise)
    begin
      // clock-synchronous: sample on programmer clock rise, lsb first
      shf_next = {rxd_s, shf_reg[7:1]};
      bit_next = bit_reg + 3'h1;
      if (bit_reg == 3'h7)
      begin
        byte_done = 1'b1;
        byte_val  = {rxd_s, shf_reg[7:1]};
      end
    end
    if (byte_done)
    begin
      bcnt_next = BUSYC;
      if (id_ok_reg || skip_id)
      begin
        cmd_v_next = 1'b1;
        cmd_b_next = byte_val;
      end
      else
      begin
        // byte k compares with stored byte k, first byte in the low lane
        mis_next = mis_reg | (byte_val != stored_id[8*idx_reg +: 8]);
        idx_next = idx_reg + 3'h1;
        if (idx_reg == IDL)
        begin
          id_ok_next = ~mis_next;
          idx_next   = 3'h0;
          mis_next   = 1'b0;
        end
      end
    end
    // mode 1 busy paces bytes; mode 2 shows receiver activity
    busy_next = uart_s ? (rx_reg != otp_pkg::RX_IDLE) | byte_done
                       : (bcnt_next != 4'h0);
    pull_next = sboot_s & ~rpin_n_s;
    if (!link_on)
    begin
      // reset pin low or not in serial boot: id gate relocks
      rx_next    = otp_pkg::RX_IDLE;
      bit_next   = 3'h0;
      idx_next   = 3'h0;
      mis_next   = 1'b0;
      id_ok_next = 1'b0;
      cmd_v_next = 1'b0;
      busy_next  = 1'b0;
      bcnt_next  = 4'h0;
    end
  end

  // register stage of the link group
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rx_reg                 <= otp_pkg::RX_IDLE;
      baud_reg               <= 16'h0;
      bit_reg                <= 3'h0;
      shf_reg                <= 8'h0;
      idx_reg                <= 3'h0;
      mis_reg                <= 1'b0;
      id_ok_reg              <= 1'b0;
      bcnt_reg               <= 4'h0;
      prog_cmd_valid         <= 1'b0;
      prog_cmd_byte          <= 8'h0;
      boot_busy              <= 1'b0;
      boot_serial_out        <= 1'b1;
      boot_serial_out_pullup <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_reg                 <= rx_next;
      baud_reg               <= baud_next;
      bit_reg                <= bit_next;
      shf_reg                <= shf_next;
      idx_reg                <= idx_next;
      mis_reg                <= mis_next;
      id_ok_reg              <= id_ok_next;
      bcnt_reg               <= bcnt_next;
      prog_cmd_valid         <= cmd_v_next;
      prog_cmd_byte          <= cmd_b_next;
      boot_busy              <= busy_next;
      boot_serial_out        <= 1'b1;                    // idle mark; replies are outside
      boot_serial_out_pullup <= pull_next;
    end
  end

endmodule

// ---- bench/otp_ctrl_props.sv ----
module otp_ctrl_props (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [7:0] prot_byte,
  input wire logic       rst_pin_n,
  input wire logic       uart_mode_in,
  input wire logic       boot_serial_out,
  input wire logic       boot_serial_out_pullup,
  input wire logic       boot_busy,
  input wire logic       par_read_block,
  input wire logic       mem_powerdown,
  input wire logic       prog_cmd_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // bus and pin relations
  // ---------------------------------------------------------------
  sequence acc_wait;
    psel && penable && !pready;
  endsequence
  sequence sync_cmd;
    prog_cmd_valid && !uart_mode_in;
  endsequence
  // exactly one wait state per access
  apb_wait_a: assert property (acc_wait |=> pready)
    else $error("access phase not answered next cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("error response without ready");
  // stop state may move only at a completing write
  pdown_write_a: assert property ($changed(mem_powerdown) |-> $past(psel && penable && pready && pwrite))
    else $error("powerdown changed outside a write");
  prot_block_a: assert property (par_read_block |-> $past(prot_byte) == 8'h3F)
    else $error("read block without protect code");
  txd_idle_a: assert property (boot_serial_out)
    else $error("serial output left idle level");
  pullup_pin_a: assert property (rst_pin_n [*4] |-> !boot_serial_out_pullup)
    else $error("pull-up on with reset pin high");
  cmd_pulse_a: assert property (prog_cmd_valid |=> !prog_cmd_valid)
    else $error("command strobe longer than one cycle");
  busy_win_a: assert property (sync_cmd |-> boot_busy [*8] ##1 !boot_busy)
    else $error("busy window not eight cycles");
  busy_uart_a: assert property (prog_cmd_valid && uart_mode_in |-> boot_busy)
    else $error("busy low at the end of a received frame");
endmodule

bind otp_ctrl otp_ctrl_props otp_ctrl_props_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prot_byte(prot_byte),
  .rst_pin_n(rst_pin_n), .uart_mode_in(uart_mode_in), .boot_serial_out(boot_serial_out),
  .boot_serial_out_pullup(boot_serial_out_pullup), .boot_busy(boot_busy),
  .par_read_block(par_read_block), .mem_powerdown(mem_powerdown),
  .prog_cmd_valid(prog_cmd_valid)
);

// ---- bench/otp_prog_model.sv ----
module otp_prog_model #(
  parameter int DIV = 8
) (
  input  wire logic clk_sys,
  output logic      sclk,
  output logic      sdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // serial programmer
  // ---------------------------------------------------------------
  // clock idles high between frames; data changes as the clock falls, the released line while it is high
  initial
  begin
    sclk = 1'b1;
    sdata = 1'b1;
  end
  // clock-synchronous byte, lsb first, clock low five clocks and high six clocks per bit
  task automatic sync_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      sclk <= 1'b0;
      sdata <= b[i];
      repeat (5) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (5) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    sdata <= ~b[7]; // released line: not the last value
  endtask
  // uart frame 8n1; stop bit may be made bad on purpose
  task automatic uart_byte(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    @(posedge clk_sys);
    sclk <= 1'b0; // clock input held low in uart mode
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_sys);
      sdata <= f[i];
      repeat (DIV - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    sdata <= 1'b1;
  endtask
endmodule

// ---- bench/otp_ctrl_test.sv ----
`include "otp_cfg.svh"

module otp_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int          DIV = 8;
  localparam logic [55:0] ID  = 56'h77665544332211;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, prot_byte = 8'h00, prog_cmd_byte, cmd_last = 8'h00;
  logic [31:0] pwdata = 32'h0, reset_vector = 32'h00001000, prdata, rd, cmd_cnt = 32'h0;
  logic        rst_pin_n = 1'b1, boot_mode_select_in = 1'b1, par_mode_in = 1'b0;
  logic        uart_mode_in = 1'b0, boot_sclk_in, boot_serial_in, err, pready, pslverr;
  logic        boot_serial_out, boot_serial_out_pullup, boot_busy, par_read_block;
  logic        mem_powerdown, ext_area_expand, prog_cmd_valid;
  logic [7:0]  pv [3] = '{8'h3F, 8'h00, 8'hFF};
  int          mismatches = 0, comparisons = 0;

  always #10 clk_sys = ~clk_sys;
  // command monitor
  always @(posedge clk_sys)
  if (prog_cmd_valid === 1'b1)
  begin
    cmd_cnt <= cmd_cnt + 32'h1;
    cmd_last <= prog_cmd_byte;
  end

  otp_ctrl #(.UART_DIV(DIV), .HAS_EXT_AREA(1'b1)) otp_ctrl_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .prot_byte(prot_byte), .stored_id(ID), .reset_vector(reset_vector),
    .rst_pin_n(rst_pin_n), .boot_mode_select_in(boot_mode_select_in),
    .par_mode_in(par_mode_in), .uart_mode_in(uart_mode_in), .boot_sclk_in(boot_sclk_in),
    .boot_serial_in(boot_serial_in), .boot_serial_out(boot_serial_out),
    .boot_serial_out_pullup(boot_serial_out_pullup), .boot_busy(boot_busy),
    .par_read_block(par_read_block), .mem_powerdown(mem_powerdown),
    .ext_area_expand(ext_area_expand), .prog_cmd_valid(prog_cmd_valid),
    .prog_cmd_byte(prog_cmd_byte));
  otp_prog_model #(.DIV(DIV)) otp_prog_model_inst (
    .clk_sys(clk_sys), .sclk(boot_sclk_in), .sdata(boot_serial_in));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk1(input string n, input logic s, input logic e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %b seen %b", n, e, s);
    end
  endtask
  task chk32(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer; waits are bounded, a hang ends the run
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      mismatches++;
      end_of_test();
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task done(input string n);
    $display("test %s finished", n);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    cyc(20);
    sys_rst <= 1'b0;
    cyc(3);
    apb(0, `OTP_OFS_MEMCTL, 32'h0);
    chk32("memctl", rd, 32'h0);
    apb(0, `OTP_OFS_STATUS, 32'h0);
    chk32("status", rd, 32'h0);
    apb(0, 8'h0C, 32'h0);
    chk32("unmapped", rd, 32'h0);
    chk1("slverr", err, 1'b1);
    done("registers");
    apb(1, `OTP_OFS_MEMCTL, 32'h1); // nmi high, code outside the memory
    cyc(1);
    chk1("ext_area", ext_area_expand, 1'b1);
    apb(0, `OTP_OFS_PMODE1, 32'h0);
    chk32("pmode1", rd, 32'h8);
    apb(1, `OTP_OFS_MEMCTL, 32'h0);
    cyc(1);
    chk1("ext_area", ext_area_expand, 1'b0);
    apb(1, `OTP_OFS_MEMCTL, 32'h1);
    apb(1, `OTP_OFS_PMODE1, 32'h8);
    apb(1, `OTP_OFS_MEMCTL, 32'h0);
    cyc(1);
    chk1("ext_area", ext_area_expand, 1'b1);
    apb(1, `OTP_OFS_MEMCTL, 32'h1);
    apb(1, `OTP_OFS_PMODE1, 32'h0);
    cyc(1);
    chk1("ext_area", ext_area_expand, 1'b1);
    apb(1, `OTP_OFS_MEMCTL, 32'h0);
    cyc(1);
    chk1("ext_area", ext_area_expand, 1'b0);
    done("ext_area");
    apb(1, `OTP_OFS_MEMCTL, 32'h2);
    cyc(1);
    chk1("powerdown", mem_powerdown, 1'b0);
    apb(0, `OTP_OFS_MEMCTL, 32'h0);
    chk32("memctl", rd, 32'h2);
    apb(1, `OTP_OFS_MEMCTL, 32'h3);
    cyc(1);
    chk1("powerdown", mem_powerdown, 1'b1);
    apb(1, `OTP_OFS_MEMCTL, 32'h0); // enable cleared before any stop or wait
    done("powerdown");
    par_mode_in <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      prot_byte <= pv[i];
      cyc(6);
      chk1("read_block", par_read_block, pv[i] == 8'h3F);
    end
    done("protect");
    prot_byte <= 8'h3F;
    boot_mode_select_in <= 1'b0;
    rst_pin_n <= 1'b0;
    cyc(25); // twenty or more clocks with reset pin low
    chk1("pullup", boot_serial_out_pullup, 1'b1);
    chk1("read_block", par_read_block, 1'b0);
    rst_pin_n <= 1'b1;
    cyc(5);
    chk1("pullup", boot_serial_out_pullup, 1'b0);
    for (int k = 0; k < 7; k++)
      otp_prog_model_inst.sync_byte(k == 3 ? ~ID[8*k+:8] : ID[8*k+:8]);
    cyc(20);
    chk32("cmd_count", cmd_cnt, 32'h0);
    for (int k = 0; k < 7; k++)
      otp_prog_model_inst.sync_byte(ID[8*k+:8]);
    cyc(20);
    chk32("cmd_count", cmd_cnt, 32'h0);
    apb(0, `OTP_OFS_STATUS, 32'h0);
    chk32("status", rd, 32'h5);
    otp_prog_model_inst.sync_byte(8'h1E);
    cyc(20);
    chk32("cmd_count", cmd_cnt, 32'h1);
    chk32("cmd_byte", {24'h0, cmd_last}, 32'h1E);
    done("sync_boot");
    rst_pin_n <= 1'b0;
    uart_mode_in <= 1'b1;
    reset_vector <= 32'hFFFFFFFF;
    cyc(25);
    rst_pin_n <= 1'b1;
    cyc(5);
    otp_prog_model_inst.uart_byte(8'h3C, 1'b1);
    cyc(20);
    chk32("cmd_count", cmd_cnt, 32'h2);
    chk32("cmd_byte", {24'h0, cmd_last}, 32'h3C);
    otp_prog_model_inst.uart_byte(8'hC3, 1'b0);
    cyc(40);
    chk1("bad_frame", cmd_last === 8'hC3, 1'b0);
    chk32("cmd_count", cmd_cnt, 32'h2);
    apb(0, `OTP_OFS_STATUS, 32'h0);
    chk1("uart_mode", rd[3], 1'b1);
    done("uart_boot");
    end_of_test();
  end
endmodule
